/* File: hw/rtcam_pkg.sv */
// Constants shared by the alarm match unit: offsets, field masks, resets
package rtcam_pkg;

	// Register bus widths
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;

	// Alarm1 target locations
	localparam logic [7:0] OFS_A1_SECONDS = 8'h08;
	localparam logic [7:0] OFS_A1_MINUTES = 8'h09;
	localparam logic [7:0] OFS_A1_HOURS = 8'h0a;
	localparam logic [7:0] OFS_A1_DAYS = 8'h0b;
	localparam logic [7:0] OFS_A1_MONTHS = 8'h0c;
	// Alarm2 target locations
	localparam logic [7:0] OFS_A2_MINUTES = 8'h0d;
	localparam logic [7:0] OFS_A2_HOURS = 8'h0e;
	localparam logic [7:0] OFS_A2_WEEKDAYS = 8'h0f;
	// Field enable register
	localparam logic [7:0] OFS_ENABLES = 8'h10;

	// First and last target offsets, for the storage array
	localparam logic [7:0] OFS_TGT_FIRST = OFS_A1_SECONDS;
	localparam logic [7:0] OFS_TGT_LAST = OFS_A2_WEEKDAYS;
	localparam int unsigned TGT_NUM = 8;
	localparam int unsigned TGT_IDX_W = 3;

	// Target slot indices within the storage array
	localparam logic [2:0] IDX_A1_SECONDS = 3'h0;
	localparam logic [2:0] IDX_A1_MINUTES = 3'h1;
	localparam logic [2:0] IDX_A1_HOURS = 3'h2;
	localparam logic [2:0] IDX_A1_DAYS = 3'h3;
	localparam logic [2:0] IDX_A1_MONTHS = 3'h4;
	localparam logic [2:0] IDX_A2_MINUTES = 3'h5;
	localparam logic [2:0] IDX_A2_HOURS = 3'h6;
	localparam logic [2:0] IDX_A2_WEEKDAYS = 3'h7;

	// Implemented bits in calendar mode
	localparam logic [7:0] CAL_MASK_SECONDS = 8'h7f;
	localparam logic [7:0] CAL_MASK_MINUTES = 8'h7f;
	localparam logic [7:0] CAL_MASK_HOURS = 8'h3f;
	localparam logic [7:0] CAL_MASK_DAYS = 8'h3f;
	localparam logic [7:0] CAL_MASK_MONTHS = 8'h1f;
	localparam logic [7:0] CAL_MASK_WEEKDAYS = 8'h07;

	// Implemented bits in elapsed-time mode
	localparam logic [7:0] SW_MASK_SECONDS = 8'h7f;
	localparam logic [7:0] SW_MASK_MINUTES = 8'h7f;
	localparam logic [7:0] SW_MASK_HOUR_PAIR = 8'hff;

	// Enable bit positions, calendar mode
	localparam int unsigned EN_A2_WEEKDAY = 7;
	localparam int unsigned EN_A2_HOUR = 6;
	localparam int unsigned EN_A2_MINUTE = 5;
	localparam int unsigned EN_A1_MONTH = 4;
	localparam int unsigned EN_A1_DAY = 3;
	localparam int unsigned EN_A1_HOUR = 2;
	localparam int unsigned EN_A1_MINUTE = 1;
	localparam int unsigned EN_A1_SECOND = 0;
	// Enable bit positions, elapsed-time mode
	localparam int unsigned EN_SW_A2_HOURS_HIGH = 7;
	localparam int unsigned EN_SW_A2_HOURS_LOW = 6;
	localparam int unsigned EN_SW_A1_HOURS_HIGH = 4;
	localparam int unsigned EN_SW_A1_HOURS_MID = 3;
	localparam int unsigned EN_SW_A1_HOURS_LOW = 2;

	// Alarm1 and alarm2 groups of the enable register
	localparam logic [7:0] EN_A1_GROUP = 8'h1f;
	localparam logic [7:0] EN_A2_GROUP = 8'he0;

	// Reset values
	localparam logic [7:0] RST_ENABLES = 8'h00;
	localparam logic [7:0] RST_TARGET = 8'h00;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;

endpackage : rtcam_pkg

/* File: hw/rtcam_match_unit.sv */
// Two-alarm match unit of a real-time clock, calendar and elapsed-time modes
//
// Behaviour
// - Enable bits: alarm2 7..5, alarm1 4..0.
// - Alarm1 targets held at 08h to 0Ch.
// - Calendar alarm1 compares enabled second..month fields.
// - Alarm2 targets held at 0Dh to 0Fh.
// - Calendar alarm2 compares minute, hour, weekday.
// - Disabled fields never affect the match.
// - Full enabled match on increment sets flag.
// - Flag stays set until host clears it.
// - Matching increment raises an interrupt request.
// - Elapsed alarm1 spans seconds to 999999 hours.
// - Elapsed alarm2 spans minutes to 9999 hours.
// - Elapsed targets BCD; hour bytes two digits.
// - Bits absent in both layouts store nothing; absent bits match nothing.
// - Elapsed bits 7..5 enable alarm2 fields.
// - Elapsed bits 4..0 enable alarm1 fields.
// - Mode bit set selects elapsed-time layouts.
// - Elapsed alarm1 compares seconds, minutes, hours.
// - Cleared flag resets only on next match.
`timescale 1ns/1ps

module rtcam_match_unit
	import rtcam_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Register access port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	// Mode select, from the clock's function register
	input wire logic elapsed_time_select,
	// Increment strobe from the time counters
	input wire logic time_tick,
	// Current time counters, BCD, valid with time_tick
	input wire logic [7:0] cnt_seconds,
	input wire logic [7:0] cnt_minutes,
	input wire logic [7:0] cnt_hours,
	input wire logic [7:0] cnt_days,
	input wire logic [7:0] cnt_weekdays,
	input wire logic [7:0] cnt_months,
	input wire logic [7:0] cnt_sw_hours_mid,
	input wire logic [7:0] cnt_sw_hours_high,
	// Flag clear commands from the flags register
	input wire logic alarm1_flag_clr,
	input wire logic alarm2_flag_clr,
	// Sticky flags and interrupt request pulses
	output logic alarm1_flag,
	output logic alarm2_flag,
	output logic alarm1_irq_pulse,
	output logic alarm2_irq_pulse
);

	// One field compare: a disabled field always passes
	function automatic logic field_hit(
		input logic en,
		input logic [7:0] target,
		input logic [7:0] count,
		input logic [7:0] mask
	);
		// XOR under the mask finds any differing implemented bit
		field_hit = !en || (((target ^ count) & mask) == 8'h00);
	endfunction : field_hit

	// Nonzero test of one alarm's enable group
	function automatic logic group_any(
		input logic [7:0] en,
		input logic [7:0] group
	);
		group_any = (en & group) != 8'h00;
	endfunction : group_any

	// Bits stored per target slot: union of both mode layouts
	function automatic logic [7:0] store_mask(input logic [2:0] idx);
		unique case (idx)
			IDX_A1_SECONDS: store_mask = SW_MASK_SECONDS;
			IDX_A1_MINUTES: store_mask = SW_MASK_MINUTES;
			IDX_A2_MINUTES: store_mask = SW_MASK_MINUTES;
			// Hour pairs need all eight bits in elapsed mode
			IDX_A1_HOURS: store_mask = SW_MASK_HOUR_PAIR;
			IDX_A1_DAYS: store_mask = SW_MASK_HOUR_PAIR;
			IDX_A1_MONTHS: store_mask = SW_MASK_HOUR_PAIR;
			IDX_A2_HOURS: store_mask = SW_MASK_HOUR_PAIR;
			IDX_A2_WEEKDAYS: store_mask = SW_MASK_HOUR_PAIR;
		endcase
	endfunction : store_mask

	// Bits that count in the current mode, per target slot
	function automatic logic [7:0] mode_mask(
		input logic [2:0] idx,
		input logic sw
	);
		unique case (idx)
			// Seconds and minutes keep one layout in both modes
			IDX_A1_SECONDS: mode_mask = CAL_MASK_SECONDS;
			IDX_A1_MINUTES: mode_mask = CAL_MASK_MINUTES;
			IDX_A2_MINUTES: mode_mask = CAL_MASK_MINUTES;
			IDX_A1_HOURS: mode_mask = sw ? SW_MASK_HOUR_PAIR : CAL_MASK_HOURS;
			IDX_A2_HOURS: mode_mask = sw ? SW_MASK_HOUR_PAIR : CAL_MASK_HOURS;
			IDX_A1_DAYS: mode_mask = sw ? SW_MASK_HOUR_PAIR : CAL_MASK_DAYS;
			IDX_A1_MONTHS: mode_mask = sw ? SW_MASK_HOUR_PAIR : CAL_MASK_MONTHS;
			IDX_A2_WEEKDAYS: mode_mask = sw ? SW_MASK_HOUR_PAIR : CAL_MASK_WEEKDAYS;
		endcase
	endfunction : mode_mask

	// Alarm target storage, one byte per slot
	// Hour pair slots keep all eight bits for elapsed mode
	logic [7:0] target_q [TGT_NUM];
	// Field enable register
	logic [7:0] enables_q;
	// Read data holding register
	logic [7:0] rdata_q;
	// Flags and pulses
	logic a1_flag_q;
	logic a2_flag_q;
	logic a1_pulse_q;
	logic a2_pulse_q;

	// Address decode
	// tgt_idx is only meaningful while tgt_sel is high
	logic tgt_sel;
	logic en_sel;
	logic [2:0] tgt_idx;
	logic [7:0] tgt_ofs;

	// Per-field hits
	// Slots f2..f4 change meaning with the mode
	logic a1_hit_sec;
	logic a1_hit_min;
	logic a1_hit_f2;
	logic a1_hit_f3;
	logic a1_hit_f4;
	logic a2_hit_min;
	logic a2_hit_f1;
	logic a2_hit_f2;
	// Counters seen by the mode-dependent slots
	logic [7:0] a1_cnt_f3;
	logic [7:0] a1_cnt_f4;
	logic [7:0] a2_cnt_f1;
	logic [7:0] a2_cnt_f2;
	// Whole-alarm match on this increment
	logic a1_match;
	logic a2_match;
	// At least one field enabled, per alarm
	logic a1_any_en;
	logic a2_any_en;

	// Decode: the eight target slots are contiguous
	always_comb begin
		tgt_ofs = reg_addr - OFS_TGT_FIRST;
		tgt_idx = tgt_ofs[TGT_IDX_W-1:0];
		// Out-of-range addresses wrap in tgt_ofs; tgt_sel fences them
		tgt_sel = (reg_addr >= OFS_TGT_FIRST) && (reg_addr <= OFS_TGT_LAST);
		en_sel = (reg_addr == OFS_ENABLES);
	end

	// Target registers, no reset value is defined for them
	// alarm1 slots 08h..0Ch, alarm2 slots 0Dh..0Fh
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			// A known start value keeps reads free of unknowns
			for (int i = 0; i < TGT_NUM; i++) begin
				target_q[i] <= RST_TARGET;
			end
		end else if (reg_wr && tgt_sel) begin
			target_q[tgt_idx] <= reg_wdata & store_mask(tgt_idx);
		end
	end

	// Field enable register, cleared at reset
	// alarm groups and disabled reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			enables_q <= RST_ENABLES;
		end else if (reg_wr && en_sel) begin
			// All eight bits exist in both modes
			enables_q <= reg_wdata;
		end
	end

	// Read port, data one cycle after the strobe
	// Read masking follows the mode, so absent bits read zero
	// Data stands until the next read strobe
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= RD_UNMAPPED;
		end else if (reg_rd) begin
			if (tgt_sel) begin
				rdata_q <= target_q[tgt_idx]
					& mode_mask(tgt_idx, elapsed_time_select);
			end else if (en_sel) begin
				// Enable register reads back whole
				rdata_q <= enables_q;
			end else begin
				// Unmapped locations read zero
				rdata_q <= RD_UNMAPPED;
			end
		end
	end

	// Counters behind the mode-dependent slots
	// mode bit chooses the layout
	always_comb begin
		if (elapsed_time_select) begin
			// elapsed hour bytes low, mid, high
			a1_cnt_f3 = cnt_sw_hours_mid;
			a1_cnt_f4 = cnt_sw_hours_high;
			// alarm2 hour pair low and mid
			a2_cnt_f1 = cnt_hours;
			// Alarm2 top byte lines up with the mid counter byte
			a2_cnt_f2 = cnt_sw_hours_mid;
		end else begin
			// Calendar: slots follow their names
			// day and month counters
			a1_cnt_f3 = cnt_days;
			a1_cnt_f4 = cnt_months;
			a2_cnt_f1 = cnt_hours;
			a2_cnt_f2 = cnt_weekdays;
		end
	end

	// Alarm1 field compares; enable positions coincide in both modes
	// The mode mask drops absent bits from target and counter alike
	// disabled fields always pass
	// BCD compare under the mode mask
	// absent bits take no part in a match
	always_comb begin
		a1_hit_sec = field_hit(enables_q[EN_A1_SECOND],
			target_q[IDX_A1_SECONDS], cnt_seconds,
			mode_mask(IDX_A1_SECONDS, elapsed_time_select));
		a1_hit_min = field_hit(enables_q[EN_A1_MINUTE],
			target_q[IDX_A1_MINUTES], cnt_minutes,
			mode_mask(IDX_A1_MINUTES, elapsed_time_select));
		// bit 2 also enables low hour byte
		a1_hit_f2 = field_hit(enables_q[EN_A1_HOUR],
			target_q[IDX_A1_HOURS], cnt_hours,
			mode_mask(IDX_A1_HOURS, elapsed_time_select));
		// mid and high bytes reach 999999
		a1_hit_f3 = field_hit(enables_q[EN_A1_DAY],
			target_q[IDX_A1_DAYS], a1_cnt_f3,
			mode_mask(IDX_A1_DAYS, elapsed_time_select));
		a1_hit_f4 = field_hit(enables_q[EN_A1_MONTH],
			target_q[IDX_A1_MONTHS], a1_cnt_f4,
			mode_mask(IDX_A1_MONTHS, elapsed_time_select));
	end

	// Alarm2 field compares, same masking as alarm1
	// disabled alarm2 fields always pass
	always_comb begin
		a2_hit_min = field_hit(enables_q[EN_A2_MINUTE],
			target_q[IDX_A2_MINUTES], cnt_minutes,
			mode_mask(IDX_A2_MINUTES, elapsed_time_select));
		// bits 6 and 7 enable hour bytes
		a2_hit_f1 = field_hit(enables_q[EN_A2_HOUR],
			target_q[IDX_A2_HOURS], a2_cnt_f1,
			mode_mask(IDX_A2_HOURS, elapsed_time_select));
		a2_hit_f2 = field_hit(enables_q[EN_A2_WEEKDAY],
			target_q[IDX_A2_WEEKDAYS], a2_cnt_f2,
			mode_mask(IDX_A2_WEEKDAYS, elapsed_time_select));
	end

	// Whole-alarm match, only on an increment and with any enable
	// Without the enable term an all-disabled alarm would fire each tick
	// no enables, no match
	always_comb begin
		a1_any_en = group_any(enables_q, EN_A1_GROUP);
		a2_any_en = group_any(enables_q, EN_A2_GROUP);
	end

	// Counters are valid only in the tick cycle, so the tick gates all
	// one evaluation per increment
	always_comb begin
		a1_match = time_tick && a1_any_en
			&& a1_hit_sec && a1_hit_min && a1_hit_f2
			&& a1_hit_f3 && a1_hit_f4;
		a2_match = time_tick && a2_any_en
			&& a2_hit_min && a2_hit_f1 && a2_hit_f2;
	end

	// Alarm1 sticky flag; a match wins over a clear in one cycle
	// match sets the flag
	// re-set only on a later match
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			a1_flag_q <= 1'b0;
		end else if (a1_match) begin
			// Set wins over a clear in the same cycle
			a1_flag_q <= 1'b1;
		end else if (alarm1_flag_clr) begin
			// Host clear command, no match pending
			a1_flag_q <= 1'b0;
		end
	end

	// Alarm2 sticky flag, same priority as alarm1
	// match sets the flag
	// re-set only on a later match
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			a2_flag_q <= 1'b0;
		end else if (a2_match) begin
			// A lost clear is safer than a lost alarm
			a2_flag_q <= 1'b1;
		end else if (alarm2_flag_clr) begin
			// Host clear command, no match pending
			a2_flag_q <= 1'b0;
		end
	end

	// Interrupt request pulses, repeated even if a flag is still set
	// Not gated by the flag, so an uncleared alarm still repeats
	// one pulse per matching increment
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			a1_pulse_q <= 1'b0;
			a2_pulse_q <= 1'b0;
		end else begin
			// Each pulse lasts exactly one clock
			a1_pulse_q <= a1_match;
			a2_pulse_q <= a2_match;
		end
	end

	// Outputs, all from flip-flops
	// Nothing here is combinational, so outputs move only on edges
	assign reg_rdata = rdata_q;
	assign alarm1_flag = a1_flag_q;
	assign alarm2_flag = a2_flag_q;
	assign alarm1_irq_pulse = a1_pulse_q;
	assign alarm2_irq_pulse = a2_pulse_q;

endmodule : rtcam_match_unit

/* File: bench/rtcam_match_unit_props.sv */
// Port-level checks on the alarm match unit
`timescale 1ns/1ps
module rtcam_match_props (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Register read side
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Strobe and clears
	input wire logic time_tick,
	input wire logic alarm1_flag_clr,
	input wire logic alarm2_flag_clr,
	// Flags and pulses
	input wire logic alarm1_flag,
	input wire logic alarm2_flag,
	input wire logic alarm1_irq_pulse,
	input wire logic alarm2_irq_pulse
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Clear with no tick that could set again
	sequence clr1_seq;
		alarm1_flag_clr && !time_tick;
	endsequence
	sequence clr2_seq;
		alarm2_flag_clr && !time_tick;
	endsequence
	chk_flag1_sticky: assert property (
		alarm1_flag && !alarm1_flag_clr |=> alarm1_flag)
		else $error("alarm1 flag dropped without clear");
	chk_flag2_sticky: assert property (
		alarm2_flag && !alarm2_flag_clr |=> alarm2_flag)
		else $error("alarm2 flag dropped without clear");
	chk_clear1_takes: assert property (
		clr1_seq |=> !alarm1_flag)
		else $error("alarm1 flag survived clear");
	chk_clear2_takes: assert property (
		clr2_seq |=> !alarm2_flag)
		else $error("alarm2 flag survived clear");
	chk_pulse1_cause: assert property (
		alarm1_irq_pulse |-> $past(time_tick) && alarm1_flag)
		else $error("alarm1 pulse without tick or flag");
	chk_pulse2_cause: assert property (
		alarm2_irq_pulse |-> $past(time_tick) && alarm2_flag)
		else $error("alarm2 pulse without tick or flag");
	chk_rise1_pulse: assert property (
		$rose(alarm1_flag) |-> alarm1_irq_pulse)
		else $error("alarm1 flag set without request");
	chk_rise2_pulse: assert property (
		$rose(alarm2_flag) |-> alarm2_irq_pulse)
		else $error("alarm2 flag set without request");
	chk_idle_no_set: assert property (
		!time_tick |=> !alarm1_irq_pulse && !alarm2_irq_pulse)
		else $error("request without increment");
	chk_rdata_holds: assert property (
		!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without read");
endmodule : rtcam_match_props
bind rtcam_match_unit rtcam_match_props rtcam_match_props_inst (.*);

/* File: bench/rtcam_host_model.sv */
// Host model: register writes, reads and flag clear commands
`timescale 1ns/1ps
module rtcam_host_model (
	// Clock
	input wire logic clk,
	// Register port, host side
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata,
	// Flag clear commands
	output logic alarm1_flag_clr,
	output logic alarm2_flag_clr
);
	// Idle port at time zero
	initial begin
		{reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
		{alarm1_flag_clr, alarm2_flag_clr} = 2'b00;
	end
	// callers may program fields they leave disabled
	// Write strobe one cycle; stale data inverted after
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask : wr
	// Read strobe one cycle; data valid one edge later
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask : rd
	// flags dropped by this command or by reset
	task clr(input logic [1:0] m);
		@(negedge clk);
		{alarm2_flag_clr, alarm1_flag_clr} = m;
		@(negedge clk);
		{alarm2_flag_clr, alarm1_flag_clr} = 2'b00;
	endtask : clr
endmodule : rtcam_host_model

/* File: bench/testbench.sv */
// Self-checking bench for the alarm match unit
`timescale 1ns/1ps
module testbench;
	import rtcam_pkg::*;
	// Clock, reset, register port
	logic clk, reset_n, reg_wr, reg_rd;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
	// Mode, strobe, counters
	logic elapsed_time_select, time_tick;
	logic [7:0] cnt_seconds, cnt_minutes, cnt_hours, cnt_days;
	logic [7:0] cnt_weekdays, cnt_months, cnt_sw_hours_mid, cnt_sw_hours_high;
	// Clears, flags, pulses
	logic alarm1_flag_clr, alarm2_flag_clr, alarm1_flag, alarm2_flag;
	logic alarm1_irq_pulse, alarm2_irq_pulse;
	int err_total, total_checks;
	rtcam_match_unit rtcam_match_unit_inst (.*);
	rtcam_host_model rtcam_host_model_inst (.*);
	// Compare and report
	task chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		rtcam_host_model_inst.wr(a, d);
	endtask : wr
	// Read back and compare
	task rchk(input logic [7:0] a, input logic [7:0] exp);
		rtcam_host_model_inst.rd(a, rd_val);
		chk(rd_val, exp);
	endtask : rchk
	// Tick, then {flag1, flag2, pulse1, pulse2} one cycle on
	task tick(input logic [3:0] exp);
		@(negedge clk);
		time_tick = 1'b1;
		@(negedge clk);
		time_tick = 1'b0;
		chk({4'h0, alarm1_flag, alarm2_flag, alarm1_irq_pulse,
			alarm2_irq_pulse}, {4'h0, exp});
	endtask : tick
	// Resets, unmapped read, mode masks
	task t_regs;
		rchk(OFS_ENABLES, RST_ENABLES);
		rchk(OFS_A1_SECONDS, RST_TARGET);
		rchk(8'h20, RD_UNMAPPED);
		wr(OFS_ENABLES, 8'ha5);
		rchk(OFS_ENABLES, 8'ha5);
		wr(OFS_A1_HOURS, 8'hff);
		rchk(OFS_A1_HOURS, 8'h3f);
		wr(OFS_A2_WEEKDAYS, 8'hff);
		rchk(OFS_A2_WEEKDAYS, 8'h07);
		elapsed_time_select = 1'b1;
		rchk(OFS_A1_HOURS, 8'hff);
		wr(OFS_A1_SECONDS, 8'hff);
		rchk(OFS_A1_SECONDS, 8'h7f);
		elapsed_time_select = 1'b0;
		wr(OFS_ENABLES, 8'h00);
	endtask : t_regs
	// Calendar alarms, hour target disabled and different
	task t_cal;
		wr(OFS_A1_SECONDS, 8'h30);
		wr(OFS_A1_MINUTES, 8'h15);
		wr(OFS_A1_HOURS, 8'h12);
		wr(OFS_ENABLES, 8'h03);
		cnt_seconds = 8'h30;
		cnt_minutes = 8'h15;
		cnt_hours = 8'h07;
		tick(4'ha);
		cnt_seconds = 8'h31;
		tick(4'h8);
		rtcam_host_model_inst.clr(2'b01);
		tick(4'h0);
		cnt_seconds = 8'h30;
		tick(4'ha);
		rtcam_host_model_inst.clr(2'b01);
		wr(OFS_A2_WEEKDAYS, 8'h05);
		wr(OFS_ENABLES, 8'h80);
		cnt_weekdays = 8'h05;
		tick(4'h5);
		rtcam_host_model_inst.clr(2'b10);
		wr(OFS_ENABLES, 8'h00);
		tick(4'h0);
	endtask : t_cal
	// Elapsed mode, top hour bytes of both alarms
	task t_sw;
		elapsed_time_select = 1'b1;
		wr(OFS_A1_MONTHS, 8'h99);
		wr(OFS_A2_WEEKDAYS, 8'h99);
		wr(OFS_ENABLES, 8'h90);
		cnt_sw_hours_high = 8'h99;
		cnt_sw_hours_mid = 8'h99;
		tick(4'hf);
		cnt_sw_hours_mid = 8'h98;
		tick(4'he);
		rtcam_host_model_inst.clr(2'b11);
		tick(4'ha);
	endtask : t_sw
	// Calendar hour, day, month and alarm2 hour; clear against a match
	task t_cal2;
		wr(OFS_A1_DAYS, 8'h28);
		wr(OFS_A1_MONTHS, 8'hf2);
		wr(OFS_A2_MINUTES, 8'h45);
		wr(OFS_A2_HOURS, 8'h23);
		wr(OFS_ENABLES, 8'h7c);
		cnt_hours = 8'h12;
		cnt_days = 8'h28;
		cnt_months = 8'h12;
		cnt_minutes = 8'h45;
		tick(4'ha);
		cnt_hours = 8'h23;
		tick(4'hd);
		rtcam_host_model_inst.clr(2'b11);
		cnt_days = 8'h29;
		cnt_hours = 8'h12;
		tick(4'h0);
		cnt_days = 8'h28;
		fork
			rtcam_host_model_inst.clr(2'b01);
			tick(4'ha);
		join
		rtcam_host_model_inst.clr(2'b01);
	endtask : t_cal2
	// Elapsed seconds, minutes, low and mid hours; alarm2 low hours
	task t_sw2;
		rtcam_host_model_inst.clr(2'b01);
		wr(OFS_A1_SECONDS, 8'h59);
		wr(OFS_A1_MINUTES, 8'h59);
		wr(OFS_A1_HOURS, 8'h34);
		wr(OFS_A1_DAYS, 8'h12);
		wr(OFS_A2_MINUTES, 8'h07);
		wr(OFS_A2_HOURS, 8'h34);
		wr(OFS_ENABLES, 8'h6f);
		cnt_seconds = 8'h59;
		cnt_minutes = 8'h59;
		cnt_hours = 8'h34;
		cnt_sw_hours_mid = 8'h12;
		tick(4'ha);
		cnt_minutes = 8'h07;
		tick(4'hd);
		cnt_minutes = 8'h59;
		cnt_sw_hours_mid = 8'h13;
		tick(4'hc);
	endtask : t_sw2
	// Reset in mid-run clears flags, enables and targets
	task t_rst;
		@(negedge clk);
		reset_n = 1'b0;
		@(negedge clk);
		reset_n = 1'b1;
		chk({6'h00, alarm1_flag, alarm2_flag}, 8'h00);
		rchk(OFS_ENABLES, RST_ENABLES);
		rchk(OFS_A2_HOURS, RST_TARGET);
		tick(4'h0);
	endtask : t_rst
	// Verdict and end of run
	task complete_run;
		$display("checks=%0d errors=%0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : complete_run
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Reset for three cycles, then scenarios
	initial begin
		reset_n = 1'b0;
		{elapsed_time_select, time_tick} = 2'b00;
		{cnt_seconds, cnt_minutes, cnt_hours, cnt_days} = '0;
		{cnt_weekdays, cnt_months, cnt_sw_hours_mid, cnt_sw_hours_high} = '0;
		err_total = 0;
		total_checks = 0;
		repeat (3) @(negedge clk);
		reset_n = 1'b1;
		t_regs();
		t_cal();
		t_cal2();
		t_sw();
		t_sw2();
		t_rst();
		complete_run();
	end
	// Watchdog well past the expected run of about 130 cycles
	initial begin
		#200000;
		err_total++;
		complete_run();
	end
endmodule : testbench
